/* File: rtl/pscp_pkg.sv */
// package for the phy special control and port 1 control register bank
// assumes a 16-bit host register port with byte enables and a single clock
`default_nettype none

package pscp_pkg;

   // register byte offsets
   localparam logic [7:0] PSCP_OFS_PHY1_SPECIAL = 8'h66;
   localparam logic [7:0] PSCP_OFS_PHY2_SPECIAL = 8'h6A;
   localparam logic [7:0] PSCP_OFS_PORT1_CTRL1 = 8'h6C;

   // phy special register field positions
   localparam int PSCP_PHY_POL_BIT = 5;
   localparam int PSCP_PHY_MDIX_BIT = 4;
   localparam int PSCP_PHY_FORCE_BIT = 3;
   localparam int PSCP_PHY_EEE_BIT = 2;
   localparam int PSCP_PHY_LOOP_BIT = 1;

   // port status register bits that the phy special flags mirror
   localparam int PSCP_SR_POL_BIT = 13;
   localparam int PSCP_SR_MDIX_BIT = 7;

   // port 1 control one field positions
   localparam int PSCP_P1_LED_LSB = 12;
   localparam int PSCP_P1_LED_MSB = 14;
   localparam int PSCP_P1_SAF2_BIT = 11;

   // values after reset
   localparam logic PSCP_RST_FORCE = 1'b0;
   localparam logic PSCP_RST_EEE_DIS = 1'b1;
   localparam logic PSCP_RST_LOOP = 1'b0;
   localparam logic [2:0] PSCP_RST_LED = 3'h0;
   localparam logic PSCP_RST_SAF2 = 1'b0;

   // led direct control codes
   localparam logic [2:0] PSCP_LED_BOTH_OFF = 3'h4;
   localparam logic [2:0] PSCP_LED_L0_ON = 3'h5;
   localparam logic [2:0] PSCP_LED_L1_ON = 3'h6;
   localparam logic [2:0] PSCP_LED_BOTH_ON = 3'h7;

   // host register access request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [1:0] be;
      logic [7:0] addr;
      logic [15:0] wdata;
   } pscp_req_s;

   // per-phy control bits held by the bank
   typedef struct packed {
      logic force_link;
      logic eee_dis;
      logic loopback;
   } pscp_phy_ctl_s;

endpackage

`default_nettype wire

/* File: rtl/pscp_regs.sv */
// phy special control/status registers for two phys plus port 1 control one bits 15:11
// assumes status inputs and host requests are synchronous to clk_i
`default_nettype none

module pscp_regs
   import pscp_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // host register port
   input wire pscp_req_s req_i,
   output logic [15:0] rdata_o,
   output logic rvalid_o,
   // port status register bits, index 0 is port 1
   input wire logic [15:0] port1_status_reg_i,
   input wire logic [15:0] port2_status_reg_i,
   // global led setup outputs for port 1
   input wire logic [1:0] global_led_i,
   // phy controls, index 0 is phy 1
   output logic [1:0] force_link_o,
   output logic [1:0] eee_dis_o,
   output logic [1:0] loopback_o,
   // port 1 controls
   output logic led_pin_zero_o,
   output logic led_pin_one_o,
   output logic sa_filter_mac_two_en_o
);

   pscp_phy_ctl_s phy_reg [2];
   pscp_phy_ctl_s phy_next [2];
   logic [2:0] led_ctl_reg;
   logic [2:0] led_ctl_next;
   logic saf2_reg;
   logic saf2_next;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;
   logic rvalid_reg;
   logic led_pin_zero_reg;
   logic led_pin_one_reg;
   logic led_pin_zero_next;
   logic led_pin_one_next;

   wire hit_p1 = (req_i.addr == PSCP_OFS_PHY1_SPECIAL);
   wire hit_p2 = (req_i.addr == PSCP_OFS_PHY2_SPECIAL);
   wire hit_c1 = (req_i.addr == PSCP_OFS_PORT1_CTRL1);
   wire [1:0] phy_hit = {hit_p2, hit_p1};
   wire wr_lo = req_i.wr & req_i.be[0];
   wire wr_hi = req_i.wr & req_i.be[1];
   wire [1:0] pol_stat = {port2_status_reg_i[PSCP_SR_POL_BIT],
                          port1_status_reg_i[PSCP_SR_POL_BIT]};
   wire [1:0] mdix_stat = {port2_status_reg_i[PSCP_SR_MDIX_BIT],
                           port1_status_reg_i[PSCP_SR_MDIX_BIT]};

   // read image of a phy special register
   function automatic logic [15:0] phy_image(input pscp_phy_ctl_s c, input logic pol,
                                             input logic mdix);
      logic [15:0] v;
      v = 16'h0000;
      v[PSCP_PHY_POL_BIT] = pol;
      v[PSCP_PHY_MDIX_BIT] = mdix;
      v[PSCP_PHY_FORCE_BIT] = c.force_link;
      v[PSCP_PHY_EEE_BIT] = c.eee_dis;
      v[PSCP_PHY_LOOP_BIT] = c.loopback;
      return v;
   endfunction

   // only the writable control bits take the write data
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_phy
         wire do_wr = wr_lo & phy_hit[g];
         assign phy_next[g].force_link = do_wr ? req_i.wdata[PSCP_PHY_FORCE_BIT]
                                               : phy_reg[g].force_link;
         assign phy_next[g].eee_dis = do_wr ? req_i.wdata[PSCP_PHY_EEE_BIT]
                                            : phy_reg[g].eee_dis;
         assign phy_next[g].loopback = do_wr ? req_i.wdata[PSCP_PHY_LOOP_BIT]
                                             : phy_reg[g].loopback;

         always_ff @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               phy_reg[g] <= '{PSCP_RST_FORCE, PSCP_RST_EEE_DIS, PSCP_RST_LOOP};
            end else begin
               phy_reg[g] <= phy_next[g];
            end
         end

         assign force_link_o[g] = phy_reg[g].force_link;
         assign eee_dis_o[g] = phy_reg[g].eee_dis;
         assign loopback_o[g] = phy_reg[g].loopback;
      end
   endgenerate

   // port 1 control one: bit 15 is never written
   assign led_ctl_next = (wr_hi & hit_c1) ?
                         req_i.wdata[PSCP_P1_LED_MSB:PSCP_P1_LED_LSB] : led_ctl_reg;
   assign saf2_next = (wr_hi & hit_c1) ? req_i.wdata[PSCP_P1_SAF2_BIT] : saf2_reg;

   // led direct drive, top bit clear follows global setup
   assign led_pin_zero_next = led_ctl_reg[2] ? led_ctl_reg[0] : global_led_i[0];
   assign led_pin_one_next = led_ctl_reg[2] ? led_ctl_reg[1] : global_led_i[1];

   // read mux, unmapped offsets read zero
   wire [15:0] c1_image = {1'b0, led_ctl_reg, saf2_reg, 11'h000};
   assign rdata_next = hit_p1 ? phy_image(phy_reg[0], pol_stat[0], mdix_stat[0]) :
                       hit_p2 ? phy_image(phy_reg[1], pol_stat[1], mdix_stat[1]) :
                       hit_c1 ? c1_image : 16'h0000;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         led_ctl_reg <= PSCP_RST_LED;
         saf2_reg <= PSCP_RST_SAF2;
         led_pin_zero_reg <= 1'b0;
         led_pin_one_reg <= 1'b0;
         rdata_reg <= 16'h0000;
         rvalid_reg <= 1'b0;
      end else begin
         led_ctl_reg <= led_ctl_next;
         saf2_reg <= saf2_next;
         led_pin_zero_reg <= led_pin_zero_next;
         led_pin_one_reg <= led_pin_one_next;
         rvalid_reg <= req_i.rd;
         if (req_i.rd) begin
            rdata_reg <= rdata_next;
         end
      end
   end

   assign rdata_o = rdata_reg;
   assign rvalid_o = rvalid_reg;
   assign led_pin_zero_o = led_pin_zero_reg;
   assign led_pin_one_o = led_pin_one_reg;
   assign sa_filter_mac_two_en_o = saf2_reg;

   // checks: status mirrors
   a_pol_mirror: assert property (@(posedge clk_i) disable iff (!nrst_i)
      req_i.rd && hit_p2 |=> rdata_o[PSCP_PHY_POL_BIT] == $past(port2_status_reg_i[13]))
      else $error("polarity flag does not mirror status");
   a_pol_mirror1: assert property (@(posedge clk_i) disable iff (!nrst_i)
      req_i.rd && hit_p1
      |=> rdata_o[PSCP_PHY_POL_BIT] == $past(port1_status_reg_i[PSCP_SR_POL_BIT]))
      else $error("phy 1 polarity flag does not mirror status");
   a_mdix_mirror: assert property (@(posedge clk_i) disable iff (!nrst_i)
      req_i.rd && hit_p1 |=> rdata_o[PSCP_PHY_MDIX_BIT] == $past(port1_status_reg_i[7]))
      else $error("crossover flag does not mirror status");
   a_mdix_mirror2: assert property (@(posedge clk_i) disable iff (!nrst_i)
      req_i.rd && hit_p2
      |=> rdata_o[PSCP_PHY_MDIX_BIT] == $past(port2_status_reg_i[PSCP_SR_MDIX_BIT]))
      else $error("phy 2 crossover flag does not mirror status");

   // checks: phy control bits
   a_force_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
      wr_lo && hit_p1 |=> force_link_o[0] == $past(req_i.wdata[3]))
      else $error("force link not written");
   a_force_write2: assert property (@(posedge clk_i) disable iff (!nrst_i)
      wr_lo && hit_p2 |=> force_link_o[1] == $past(req_i.wdata[PSCP_PHY_FORCE_BIT]))
      else $error("phy 2 force link not written");
   a_eee_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
      wr_lo && hit_p1 |=> eee_dis_o[0] == $past(req_i.wdata[PSCP_PHY_EEE_BIT]))
      else $error("eee disable not written");
   a_eee_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !(wr_lo && hit_p2) |=> $stable(eee_dis_o[1]))
      else $error("eee disable changed without write");
   a_eee_hold1: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !(wr_lo && hit_p1) |=> $stable(eee_dis_o[0]))
      else $error("phy 1 eee disable changed without write");
   a_loop_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
      wr_lo && hit_p2 |=> loopback_o[1] == $past(req_i.wdata[1]))
      else $error("loopback not written");
   a_loop_write1: assert property (@(posedge clk_i) disable iff (!nrst_i)
      wr_lo && hit_p1 |=> loopback_o[0] == $past(req_i.wdata[PSCP_PHY_LOOP_BIT]))
      else $error("phy 1 loopback not written");
   a_reserved_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
      req_i.rd && (hit_p1 || hit_p2) |=> rdata_o[15:6] == 10'h000 && !rdata_o[0])
      else $error("reserved phy bits read nonzero");

   // checks: led pins
   a_led_direct: assert property (@(posedge clk_i) disable iff (!nrst_i)
      wr_hi && hit_c1 && req_i.wdata[14:12] == PSCP_LED_L1_ON ##1 !(wr_hi && hit_c1)
      |=> led_pin_one_o && !led_pin_zero_o)
      else $error("led direct code 110 not driven");
   a_led_follow: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !led_ctl_reg[2] |=> led_pin_zero_o == $past(global_led_i[0])
         && led_pin_one_o == $past(global_led_i[1]))
      else $error("leds do not follow global setup");
   a_led_off: assert property (@(posedge clk_i) disable iff (!nrst_i)
      led_ctl_reg == PSCP_LED_BOTH_OFF |=> !led_pin_zero_o && !led_pin_one_o)
      else $error("led direct code 100 not driven");
   a_led_l0: assert property (@(posedge clk_i) disable iff (!nrst_i)
      led_ctl_reg == PSCP_LED_L0_ON |=> led_pin_zero_o && !led_pin_one_o)
      else $error("led direct code 101 not driven");
   a_led_on: assert property (@(posedge clk_i) disable iff (!nrst_i)
      led_ctl_reg == PSCP_LED_BOTH_ON |=> led_pin_zero_o && led_pin_one_o)
      else $error("led direct code 111 not driven");

   // checks: port 1 control one
   a_saf2_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
      wr_hi && hit_c1 |=> sa_filter_mac_two_en_o == $past(req_i.wdata[11]))
      else $error("filter enable not written");
   a_saf2_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !(wr_hi && hit_c1) |=> $stable(sa_filter_mac_two_en_o))
      else $error("filter enable changed without write");
   a_c1_top_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
      req_i.rd && hit_c1 |=> !rdata_o[15])
      else $error("reserved port 1 bit 15 reads one");

   // checks: writes that must leave state alone, reads that must return zero
   a_lo_ignore: assert property (@(posedge clk_i) disable iff (!nrst_i)
      wr_hi && !wr_lo |=> $stable(force_link_o) && $stable(loopback_o))
      else $error("phy bits changed by high byte write");
   a_eee_lo_ignore: assert property (@(posedge clk_i) disable iff (!nrst_i)
      wr_hi && !wr_lo |=> $stable(eee_dis_o))
      else $error("eee disable changed by high byte write");
   a_c1_lo_ignore: assert property (@(posedge clk_i) disable iff (!nrst_i)
      wr_lo && !wr_hi && hit_c1 |=> $stable(led_ctl_reg) && $stable(sa_filter_mac_two_en_o))
      else $error("port 1 bits changed by low byte write");
   a_c1_low_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
      req_i.rd && hit_c1 |=> rdata_o[10:0] == 11'h000)
      else $error("unimplemented port 1 bits read nonzero");
   a_unmapped_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
      req_i.rd && !(hit_p1 || hit_p2 || hit_c1) |=> rdata_o == 16'h0000)
      else $error("unmapped offset reads nonzero");

endmodule

`default_nettype wire

/* File: bench/pscp_regs_tb.sv */
// testbench for the phy special and port 1 control register bank
// assumes the host register port is driven directly, no far-side model
`default_nettype none
module pscp_regs_tb
   import pscp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i, nrst_i, rvalid, led_pin_zero, led_pin_one, saf;
   pscp_req_s req;
   logic [15:0] rdata, p1s, p2s;
   logic [1:0] gled, frc, eee, lpb;
   logic [2:0] c;
   int bad_count, n_compared;
   int cycles = 0;

   pscp_regs pscp_regs_i (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(req), .rdata_o(rdata),
      .rvalid_o(rvalid), .port1_status_reg_i(p1s), .port2_status_reg_i(p2s),
      .global_led_i(gled), .force_link_o(frc), .eee_dis_o(eee), .loopback_o(lpb),
      .led_pin_zero_o(led_pin_zero), .led_pin_one_o(led_pin_one), .sa_filter_mac_two_en_o(saf));

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one idle edge, then one read; answer checked just after the taking edge
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      pscp_req_s r;
      r = '0;
      r.rd = 1'b1;
      r.addr = a;
      @(posedge clk_i);
      #1;
      req = r;
      @(posedge clk_i);
      #1;
      req = '0;
      chk("rvalid", {15'h0, rvalid}, 16'h0001);
      chk("rdata", rdata, exp);
   endtask

   // one idle edge, then one write held through its taking edge
   task automatic wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] wd);
      pscp_req_s r;
      r = '0;
      r.wr = 1'b1;
      r.be = be;
      r.addr = a;
      r.wdata = wd;
      @(posedge clk_i);
      #1;
      req = r;
      @(posedge clk_i);
      #1;
      req = '0;
   endtask

   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         tally_and_finish();
      end
   end

   initial begin
      nrst_i = 1'b0;
      req = '0;
      p1s = 16'h0000;
      p2s = 16'h0000;
      gled = 2'b10;
      bad_count = 0;
      n_compared = 0;
      repeat (16) @(posedge clk_i);
      #1;
      nrst_i = 1'b1;
      chk("ctl", {10'h0, frc, eee, lpb}, 16'h000C);
      chk("saf", {15'h0, saf}, 16'h0000);
      rd(PSCP_OFS_PHY1_SPECIAL, 16'h0004);
      rd(PSCP_OFS_PORT1_CTRL1, 16'h0000);
      $display("test reset done");
      p1s = 16'h2000;
      p2s = 16'h0080;
      rd(PSCP_OFS_PHY1_SPECIAL, 16'h0024);
      rd(PSCP_OFS_PHY2_SPECIAL, 16'h0014);
      p1s = 16'hDF7F;
      rd(PSCP_OFS_PHY1_SPECIAL, 16'h0004);
      $display("test status mirror done");
      wr(PSCP_OFS_PHY1_SPECIAL, 2'b11, 16'hFFFF);
      rd(PSCP_OFS_PHY1_SPECIAL, 16'h000E);
      chk("ctl", {10'h0, frc, eee, lpb}, 16'h001D);
      wr(PSCP_OFS_PHY2_SPECIAL, 2'b11, 16'h0000);
      wr(PSCP_OFS_PHY1_SPECIAL, 2'b10, 16'h0000);
      chk("ctl", {10'h0, frc, eee, lpb}, 16'h0015);
      rd(PSCP_OFS_PHY2_SPECIAL, 16'h0010);
      wr(PSCP_OFS_PHY1_SPECIAL, 2'b11, 16'h0000);
      chk("ctl", {10'h0, frc, eee, lpb}, 16'h0000);
      wr(8'h68, 2'b11, 16'hFFFF);
      rd(8'h68, 16'h0000);
      rd(PSCP_OFS_PHY1_SPECIAL, 16'h0000);
      $display("test phy controls done");
      for (int i = 0; i < 8; i++) begin
         c = i[2:0];
         gled = c[1:0] ^ 2'b11;
         wr(PSCP_OFS_PORT1_CTRL1, 2'b11, {1'b1, c, 12'hFFF});
         rd(PSCP_OFS_PORT1_CTRL1, {1'b0, c, 12'h800});
         chk("led", {14'h0, led_pin_one, led_pin_zero}, {14'h0, c[2] ? c[1:0] : gled});
      end
      chk("saf", {15'h0, saf}, 16'h0001);
      wr(PSCP_OFS_PORT1_CTRL1, 2'b01, 16'h0000);
      rd(PSCP_OFS_PORT1_CTRL1, 16'h7800);
      $display("test port 1 control done");
      nrst_i = 1'b0;
      gled = 2'b01;
      repeat (2) @(posedge clk_i);
      #1;
      nrst_i = 1'b1;
      chk("ctl", {10'h0, frc, eee, lpb}, 16'h000C);
      chk("saf", {15'h0, saf}, 16'h0000);
      rd(PSCP_OFS_PORT1_CTRL1, 16'h0000);
      chk("led", {14'h0, led_pin_one, led_pin_zero}, {14'h0, gled});
      $display("test mid-run reset done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
